/* rtl/aic_gain_sel.sv */
`timescale 1ns/1ps
// Chooses bridge or single-ended bank and folds the mute bits in
module aic_gain_sel
	import aic_pkg::*;
(
	input  wire logic [7:0] bridge_reg,
	input  wire logic [7:0] single_reg,
	input  wire logic       use_single,
	input  wire logic       global_mute,
	output aic_gain_t       gain
);
	logic [7:0] sel;
	always_comb begin
		sel = use_single ? single_reg : bridge_reg;
		gain.code = sel[5:0];
		gain.mute = sel[GAIN_MUTE_HI] | sel[GAIN_MUTE_LO] | global_mute;
	end
endmodule : aic_gain_sel

/* rtl/aic_pkg.sv */
// How it works
// - Only whole multi-byte transfers reach registers
// - Reads return all six registers in turn
// - Gain code maps linearly, 1.25 dB steps
// - Either mute bit silences the channel
// - Mask resets to ones; bits 0..2 used
// - Mask bit one: external pin governs
// - Mask bit zero: control bit governs
// - Mask bit 2 one forces tone auto-detect
// - Mask bit 7 is read-only power-up flag
// - Control register resets zero; fixed bit map
// - Address 11011 plus two strap bits
// - Bus clock up to 400 kHz from master
// - Acknowledge address and each of the first six written bytes
// - Control bit 0 high means power-down
package aic_pkg;
	localparam int NUM_REGS = 6;
	localparam logic [4:0] ADDR_FIXED = 5'h1b;
	localparam logic [7:0] GAIN_RESET = 8'h3f;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] IDX_BR_R = 3'h0;
	localparam logic [2:0] IDX_BR_L = 3'h1;
	localparam logic [2:0] IDX_SE_R = 3'h2;
	localparam logic [2:0] IDX_SE_L = 3'h3;
	localparam logic [2:0] IDX_MASK = 3'h4;
	localparam logic [2:0] IDX_CTRL = 3'h5;
	localparam int MASK_PDN = 0;
	localparam int MASK_TOPO = 1;
	localparam int MASK_TONE = 2;
	localparam int MASK_FLAG = 7;
	localparam int CTRL_PDN = 0;
	localparam int CTRL_SRC = 1;
	localparam int CTRL_MUTE = 3;
	localparam int CTRL_TOPO = 5;
	localparam int CTRL_BANK = 6;
	localparam int CTRL_TONE = 7;
	localparam int GAIN_MUTE_LO = 6;
	localparam int GAIN_MUTE_HI = 7;
	// Power-up sequence length; 50 ms at 25 MHz
	localparam int PWRUP_MS = 50;
	localparam int CLK_KHZ = 25000;
	localparam int PWRUP_CYCLES = PWRUP_MS * CLK_KHZ;
	typedef struct packed {
		logic       mute;
		logic [5:0] code;
	} aic_gain_t;
	typedef struct packed {
		logic [7:0] data;
		logic       wr;
		logic       last;
	} aic_wbyte_t;
endpackage : aic_pkg

/* rtl/aic_regs.sv */
`timescale 1ns/1ps
module aic_regs
	import aic_pkg::*;
#(
	parameter int PWRUP_LEN = PWRUP_CYCLES
)
(
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE,
	input  wire logic       ADDR_STRAP_HIGH,
	input  wire logic       ADDR_STRAP_LOW,
	input  wire logic       POWER_DOWN_PIN_N,
	input  wire logic       OUTPUT_TOPOLOGY_SELECT,
	output logic            POWER_DOWN,
	output logic            INPUT_SOURCE_SELECT,
	output logic            SINGLE_ENDED_OUTPUT,
	output logic            TONE_FORCE,
	output logic [5:0]      RIGHT_GAIN_CODE,
	output logic            RIGHT_MUTE,
	output logic [5:0]      LEFT_GAIN_CODE,
	output logic            LEFT_MUTE,
	output logic            POWERING_UP
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_WRX  = 6'b000100,
		ST_RTX  = 6'b001000,
		ST_ACK  = 6'b010000,
		ST_MACK = 6'b100000
	} aic_state_t;

	logic scl, sda, scl_d, sda_d;
	logic pdn_pin, topo_pin;
	aic_sync u_scl (.CLK(CLK), .SYS_RST(SYS_RST), .din(SCL_I), .dout(scl));
	aic_sync u_sda (.CLK(CLK), .SYS_RST(SYS_RST), .din(SDA_I), .dout(sda));
	aic_sync u_pdn (.CLK(CLK), .SYS_RST(SYS_RST), .din(POWER_DOWN_PIN_N),
		.dout(pdn_pin));
	aic_sync u_topo (.CLK(CLK), .SYS_RST(SYS_RST),
		.din(OUTPUT_TOPOLOGY_SELECT), .dout(topo_pin));

	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_c = scl & scl_d & sda_d & ~sda;
	assign stop_c = scl & scl_d & ~sda_d & sda;

	aic_state_t state, next_state;
	logic [7:0] regs [NUM_REGS];
	logic [7:0] stage [NUM_REGS];
	logic [7:0] shreg, next_shreg;
	logic [3:0] bitcnt, next_bitcnt;
	logic [2:0] idx, next_idx;
	logic       rnw, next_rnw, drive, next_drive, acked, next_acked;
	logic [7:0] next_regs [NUM_REGS];
	logic [7:0] next_stage [NUM_REGS];
	logic [22:0] pcnt, next_pcnt;
	logic        pwr, next_pwr;

	// power-up flag runs from reset for a fixed time
	always_comb begin
		next_pcnt = pcnt;
		next_pwr = pwr;
		if (pwr) begin
			if (pcnt == 23'(PWRUP_LEN - 1))
				next_pwr = 1'b0;
			else
				next_pcnt = pcnt + 23'h1;
		end
	end

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_idx = idx;
		next_rnw = rnw;
		next_drive = drive;
		next_acked = acked;
		next_regs = regs;
		next_stage = stage;
		if (start_c) begin
			next_state = ST_ADDR;
			next_bitcnt = 4'h0;
			next_idx = 3'h0;
			next_drive = 1'b0;
		end else if (stop_c) begin
			// commit only a complete six-byte write
			if (state != ST_IDLE && !rnw && idx == 3'(NUM_REGS)) begin
				for (int i = 0; i < NUM_REGS; i++)
					next_regs[i] = stage[i];
				next_regs[IDX_MASK][MASK_FLAG] = 1'b1;
			end
			next_state = ST_IDLE;
			next_drive = 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				next_drive = 1'b0;
			end
			ST_ADDR, ST_WRX: begin
				if (scl_rise) begin
					next_shreg = {shreg[6:0], sda};
					next_bitcnt = bitcnt + 4'h1;
				end
				if (scl_fall && bitcnt == 4'h8) begin
					next_bitcnt = 4'h0;
					if (state == ST_ADDR) begin
						if (shreg[7:1] == {ADDR_FIXED, ADDR_STRAP_HIGH,
								ADDR_STRAP_LOW}) begin
							next_rnw = shreg[0];
							next_drive = 1'b1;
							next_acked = 1'b1;
							next_state = ST_ACK;
						end else
							next_state = ST_IDLE;
					end else if (idx < 3'(NUM_REGS)) begin
						next_stage[idx] = shreg;
						next_idx = idx + 3'h1;
						next_drive = 1'b1;
						next_state = ST_ACK;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					if (rnw) begin
						next_shreg = (idx == IDX_MASK) ?
							{pwr, regs[IDX_MASK][6:0]} : regs[idx];
						next_drive = ~next_shreg[7];
						next_bitcnt = 4'h1;
						next_state = ST_RTX;
					end else begin
						next_drive = 1'b0;
						next_state = ST_WRX;
					end
				end
			end
			ST_RTX: begin
				if (scl_fall) begin
					if (bitcnt == 4'h8) begin
						next_drive = 1'b0;
						next_bitcnt = 4'h0;
						next_state = ST_MACK;
					end else begin
						next_shreg = {shreg[6:0], 1'b0};
						next_drive = ~shreg[6];
						next_bitcnt = bitcnt + 4'h1;
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					// stop after six or on master nack
					if (sda || idx == 3'(NUM_REGS - 1))
						next_state = ST_IDLE;
					else begin
						next_idx = idx + 3'h1;
						next_state = ST_ACK;
					end
				end
			end
			default: next_state = ST_IDLE;
			endcase
		end
		if (state == ST_ACK && rnw && scl_fall && idx == 3'h0 && !acked)
			next_drive = next_drive;
		if (state == ST_ACK && !scl_fall)
			next_acked = acked;
	end

	// Master-ack path reuses ST_ACK with no drive; first byte keeps idx 0
	logic next_sda_o;
	aic_gain_t gr, gl;
	logic use_single, topo_se, pdn_eff, tone_f;
	always_comb begin
		// mask set: pin governs; mask clear: control bit
		// control bit high powers down, pin is active low
		pdn_eff = regs[IDX_MASK][MASK_PDN] ? ~pdn_pin :
			regs[IDX_CTRL][CTRL_PDN];
		topo_se = regs[IDX_MASK][MASK_TOPO] ? topo_pin :
			regs[IDX_CTRL][CTRL_TOPO];
		use_single = regs[IDX_MASK][MASK_TOPO] ? topo_pin :
			regs[IDX_CTRL][CTRL_BANK];
		// mask bit 2 set forces auto-detect
		tone_f = ~regs[IDX_MASK][MASK_TONE] & regs[IDX_CTRL][CTRL_TONE];
		next_sda_o = 1'b0;
	end
	// code passes straight to the linear gain ladder
	aic_gain_sel u_gr (.bridge_reg(regs[IDX_BR_R]),
		.single_reg(regs[IDX_SE_R]), .use_single(use_single),
		.global_mute(regs[IDX_CTRL][CTRL_MUTE]), .gain(gr));
	aic_gain_sel u_gl (.bridge_reg(regs[IDX_BR_L]),
		.single_reg(regs[IDX_SE_L]), .use_single(use_single),
		.global_mute(regs[IDX_CTRL][CTRL_MUTE]), .gain(gl));

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= ST_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			idx <= 3'h0;
			rnw <= 1'b0;
			drive <= 1'b0;
			acked <= 1'b0;
			pcnt <= 23'h0;
			pwr <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				regs[i] <= GAIN_RESET;
				stage[i] <= GAIN_RESET;
			end
			regs[IDX_MASK] <= MASK_RESET;
			stage[IDX_MASK] <= MASK_RESET;
			regs[IDX_CTRL] <= CTRL_RESET;
			stage[IDX_CTRL] <= CTRL_RESET;
			SDA_O <= 1'b0;
			SDA_OE <= 1'b1;
			POWER_DOWN <= 1'b0;
			INPUT_SOURCE_SELECT <= 1'b0;
			SINGLE_ENDED_OUTPUT <= 1'b0;
			TONE_FORCE <= 1'b0;
			RIGHT_GAIN_CODE <= 6'h3f;
			RIGHT_MUTE <= 1'b0;
			LEFT_GAIN_CODE <= 6'h3f;
			LEFT_MUTE <= 1'b0;
			POWERING_UP <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			state <= next_state;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			idx <= next_idx;
			rnw <= next_rnw;
			drive <= next_drive;
			acked <= next_acked;
			pcnt <= next_pcnt;
			pwr <= next_pwr;
			regs <= next_regs;
			stage <= next_stage;
			SDA_O <= next_sda_o;
			// Enable is low while pulling the line low
			SDA_OE <= ~next_drive;
			POWER_DOWN <= pdn_eff;
			INPUT_SOURCE_SELECT <= regs[IDX_MASK][MASK_TOPO] ? topo_pin :
				regs[IDX_CTRL][CTRL_SRC];
			SINGLE_ENDED_OUTPUT <= topo_se;
			TONE_FORCE <= tone_f;
			RIGHT_GAIN_CODE <= gr.code;
			RIGHT_MUTE <= gr.mute;
			LEFT_GAIN_CODE <= gl.code;
			LEFT_MUTE <= gl.mute;
			POWERING_UP <= pwr;
		end
	end
endmodule : aic_regs

/* rtl/aic_sync.sv */
`timescale 1ns/1ps
// Three-stage input synchroniser; output changes when stages 2 and 3 agree
module aic_sync
	import aic_pkg::*;
(
	input  wire logic CLK,
	input  wire logic SYS_RST,
	input  wire logic din,
	output logic      dout
);
	logic [2:0] sh;
	logic [2:0] next_sh;
	logic       next_dout;
	always_comb begin
		next_sh = {sh[1:0], din};
		next_dout = (sh[2] == sh[1]) ? sh[2] : dout;
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sh <= 3'h7;
			dout <= 1'b1;
		end else begin
			sh <= next_sh;
			dout <= next_dout;
		end
	end
endmodule : aic_sync

/* tb/aic_host_model.sv */
`timescale 1ns/1ps
module aic_host_model
	import aic_pkg::*;
(
	input  wire logic CLK,
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_drv
);
	logic [7:0] data [NUM_REGS];
	logic [7:0] acks;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Eight clocks per bit
	// Long low phase: the device answers five clocks after a fall,
	// so the clock must not rise before its data has settled
	task automatic bit_cyc(input logic b, output logic s);
		repeat (2) @(posedge CLK);
		sda_drv <= b;
		repeat (4) @(posedge CLK);
		scl <= 1'b1;
		repeat (2) @(posedge CLK);
		s = sda_in;
		scl <= 1'b0;
	endtask : bit_cyc
	task automatic frame(input logic [7:0] adr, input int n);
		logic       s;
		logic [7:0] b;
		acks = 8'h00;
		sda_drv <= 1'b0;
		repeat (4) @(posedge CLK);
		scl <= 1'b0;
		for (int i = 0; i <= n; i++) begin
			b = (i == 0) ? adr : (adr[0] ? 8'hff : data[i - 1]);
			for (int k = 7; k >= 0; k--) begin
				bit_cyc(b[k], s);
				b[k] = s;
			end
			if (i > 0)
				data[i - 1] = b;
			bit_cyc(!(adr[0] && i > 0 && i < n), s);
			acks[i] = !s;
		end
		repeat (2) @(posedge CLK);
		sda_drv <= 1'b0;
		repeat (4) @(posedge CLK);
		scl <= 1'b1;
		repeat (4) @(posedge CLK);
		sda_drv <= 1'b1;
		repeat (16) @(posedge CLK);
	endtask : frame
endmodule : aic_host_model

/* tb/aic_regs_assertions.sv */
`timescale 1ns/1ps
module aic_regs_assertions
	import aic_pkg::*;
#(
	parameter int PWRUP_LEN = PWRUP_CYCLES
)
(
	input wire logic       CLK,
	input wire logic       SYS_RST,
	input wire logic       SCL_I,
	input wire logic       SDA_O,
	input wire logic       SDA_OE,
	input wire logic [5:0] RIGHT_GAIN_CODE,
	input wire logic       RIGHT_MUTE,
	input wire logic [5:0] LEFT_GAIN_CODE,
	input wire logic       POWERING_UP
);
	logic [31:0] cyc;
	logic [31:0] next_cyc;
	always_comb begin
		next_cyc = SYS_RST ? 32'h0 : cyc + 32'h1;
	end
	always_ff @(posedge CLK) begin
		cyc <= next_cyc;
	end
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	sequence s_oe_fall;
		$fell(SDA_OE);
	endsequence
	// Data line may change only while the bus clock is low
	sequence s_scl_low_lately;
		!SCL_I && !$past(SCL_I);
	endsequence
	a_reset_state: assert property ($fell(SYS_RST) |-> SDA_OE
		&& POWERING_UP && RIGHT_GAIN_CODE == 6'h3f
		&& LEFT_GAIN_CODE == 6'h3f && !RIGHT_MUTE)
		else $error("outputs wrong after reset");
	a_sda_low_only: assert property (!SDA_O)
		else $error("data pin driven high");
	a_ack_min_width: assert property (s_oe_fall |-> !SDA_OE [*5])
		else $error("acknowledge too short");
	a_ack_after_fall: assert property (s_oe_fall |-> s_scl_low_lately)
		else $error("data pulled low while clock high");
	a_rel_after_fall: assert property ($rose(SDA_OE) |-> s_scl_low_lately)
		else $error("data released while clock high");
	a_flag_held: assert property (cyc + 32'h2 < PWRUP_LEN |-> POWERING_UP)
		else $error("power-up flag dropped early");
	a_flag_cleared: assert property (cyc > PWRUP_LEN + 4 |-> !POWERING_UP)
		else $error("power-up flag stuck");
	a_flag_stays: assert property (!POWERING_UP |=> !POWERING_UP)
		else $error("power-up flag rose again");
endmodule : aic_regs_assertions

bind aic_regs aic_regs_assertions #(.PWRUP_LEN(PWRUP_LEN)) chk (
	.CLK(CLK), .SYS_RST(SYS_RST), .SCL_I(SCL_I), .SDA_O(SDA_O),
	.SDA_OE(SDA_OE), .RIGHT_GAIN_CODE(RIGHT_GAIN_CODE),
	.RIGHT_MUTE(RIGHT_MUTE), .LEFT_GAIN_CODE(LEFT_GAIN_CODE),
	.POWERING_UP(POWERING_UP));

/* tb/tb.sv */
`timescale 1ns/1ps
module tb
	import aic_pkg::*;
;
	localparam logic [7:0] ADR = {ADDR_FIXED, 2'b10, 1'b0};
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       scl;
	logic       drv;
	logic       sda_o;
	logic       sda_oe;
	logic       pdn_n = 1'b1;
	logic       topo = 1'b0;
	logic [5:0] rcode;
	logic [5:0] lcode;
	wire  [7:0] outs;
	int         miscompares = 0;
	int         checks_done = 0;
	// Pull-up on the data line: released means high
	wire        sda = drv & (sda_oe | sda_o);
	assign outs[0] = 1'b0;
	aic_host_model host (.CLK(clk), .sda_in(sda), .scl(scl), .sda_drv(drv));
	aic_regs #(.PWRUP_LEN(2000)) uut (
		.CLK(clk), .SYS_RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE(sda_oe), .ADDR_STRAP_HIGH(1'b1), .ADDR_STRAP_LOW(1'b0),
		.POWER_DOWN_PIN_N(pdn_n), .OUTPUT_TOPOLOGY_SELECT(topo),
		.POWER_DOWN(outs[7]), .INPUT_SOURCE_SELECT(outs[6]),
		.SINGLE_ENDED_OUTPUT(outs[5]), .TONE_FORCE(outs[4]),
		.RIGHT_GAIN_CODE(rcode), .RIGHT_MUTE(outs[3]),
		.LEFT_GAIN_CODE(lcode), .LEFT_MUTE(outs[2]), .POWERING_UP(outs[1]));
	always #20 clk = ~clk;
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [47:0] v, input int n);
		for (int i = 0; i < 6; i++)
			host.data[i] = v[47 - 8 * i -: 8];
		host.frame(ADR, n);
		check("write acks", host.acks, 8'hff >> (7 - n));
		repeat (8) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [47:0] v);
		host.frame(ADR | 8'h01, 6);
		check("addr ack", {7'h0, host.acks[0]}, 8'h01);
		for (int i = 0; i < 6; i++)
			check("read byte", host.data[i], v[47 - 8 * i -: 8]);
	endtask : rd
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		check("pins", outs, 8'h02);
		check("code", {2'h0, rcode}, 8'h3f);
		rd(48'h3f3f_3f3f_ff00);
		for (int i = 0; i < 8 && host.data[4][7] !== 1'b0; i++)
			host.frame(ADR | 8'h01, 6);
		rd(48'h3f3f_3f3f_7f00);
		$display("test reset done");
		wr(48'h0001_458a_00c3, 6);
		check("ctrl gov", outs, 8'hdc);
		rd(48'h0001_458a_00c3);
		wr(48'h0001_458a_0020, 6);
		check("bridge", outs, 8'h20);
		check("right code", {2'h0, rcode}, 8'h00);
		check("left code", {2'h0, lcode}, 8'h01);
		wr(48'hffff_ffff_ffff, 3);
		check("short", outs, 8'h20);
		rd(48'h0001_458a_0020);
		$display("test control done");
		wr(48'h0001_458a_ff81, 6);
		rd(48'h0001_458a_7f81);
		for (int p = 0; p < 2; p++) begin
			pdn_n <= p[0];
			topo <= p[0];
			repeat (10) @(posedge clk);
			check("pin gov", outs,
				{!p[0], p[0], p[0], 1'b0, p[0], p[0], 2'b00});
		end
		$display("test mask done");
		for (int a = 0; a < 4; a++) begin
			host.frame({ADDR_FIXED, a[1:0], 1'b0}, 0);
			check("addr", {7'h0, host.acks[0]}, {7'h0, a == 2});
		end
		$display("test address done");
		wrap_up();
	end
endmodule : tb
